/* File: hw/bmx_consts.vh */
// Shared constants for the bus matrix, the peripheral bridges and the write-protect registers.
// Assumes inclusion by bare name from every design file that needs a number below.
`ifndef BMX_CONSTS_VH
`define BMX_CONSTS_VH

// ----------------------------------------------------------------
// Master and slave numbering
// ----------------------------------------------------------------
`define MST_CORE 1'h0
`define MST_DEBUG 1'h1
`define SLV_FLASH 3'h0
`define SLV_BRIDGE_A 3'h1
`define SLV_BRIDGE_B 3'h2
`define SLV_BRIDGE_C 3'h3
`define SLV_NONE 3'h4

// ----------------------------------------------------------------
// Address regions seen by the masters
// ----------------------------------------------------------------
`define FLASH_REGION 4'h0
`define BRIDGE_A_REGION 16'h4000
`define BRIDGE_B_REGION 16'h4100
`define BRIDGE_C_REGION 16'h4200
`define SLOT_MSB 14
`define SLOT_LSB 10

// ----------------------------------------------------------------
// AHB transfer encodings
// ----------------------------------------------------------------
`define HTRANS_IDLE 2'h0
`define HTRANS_NONSEQ 2'h2
`define HSIZE_BYTE 3'h0
`define HSIZE_HALF 3'h1

// ----------------------------------------------------------------
// Protect register map on the configuration port
// ----------------------------------------------------------------
`define OFF_A_CLEAR 12'h000
`define OFF_A_SET 12'h004
`define OFF_B_CLEAR 12'h010
`define OFF_B_SET 12'h014
`define OFF_C_CLEAR 12'h020
`define OFF_C_SET 12'h024

// ----------------------------------------------------------------
// Implemented protect bits and their reset values
// ----------------------------------------------------------------
`define PROT_W 17
// Bridge A: ext interrupt 6, rt counter 5, watchdog 4, clock gen 3, sys ctrl 2, power mgr 1
`define MASK_A 17'h0007e
`define RESET_A 17'h00000
// Bridge B: trace buffer 6, port ctrl 3, flash ctrl 2, debug unit 1
`define MASK_B 17'h0004e
`define RESET_B 17'h00002
// Bridge C: converter 16, timers 15..8, serial 7..2, event system 1
`define MASK_C 17'h1fffe
`define RESET_C 17'h00000

`endif

/* File: hw/protect_regs.v */
// One bridge's write-protect state with its clear and set write ports.
// Assumes the caller decodes the register offsets and hands in committed write pulses.
`timescale 1ns/1ps
module protect_regs #(
	parameter [16:0] MASK = 17'h00000,
	parameter [16:0] RESET = 17'h00000
) (
	input wire pclk,
	input wire presetn,
	input wire clr_we,
	input wire set_we,
	input wire [16:0] wdata,
	output reg [16:0] prot_q
);
	wire [16:0] clr_bits;
	wire [16:0] set_bits;

	// Ones clear or set, zeros leave the bit alone; unimplemented bits stay zero
	assign clr_bits = clr_we ? (wdata & MASK) : 17'h00000;
	assign set_bits = set_we ? (wdata & MASK) : 17'h00000;

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prot_q <= RESET;
		else
			prot_q <= (prot_q & ~clr_bits) | set_bits;
	end
endmodule // protect_regs

/* File: hw/apb_bridge.v */
// AHB-side request engine that turns one matrix request into one combined APB cycle.
// Assumes start is a one-cycle pulse with the request fields valid in that cycle.
`timescale 1ns/1ps
`include "bmx_consts.vh"
module apb_bridge (
	input wire pclk,
	input wire presetn,
	input wire clock_on,
	input wire start,
	input wire [31:0] addr,
	input wire write,
	input wire [2:0] size,
	input wire [3:0] hprot,
	input wire [31:0] wdata,
	input wire [16:0] protect,
	output reg psel_q,
	output reg penable_q,
	output reg [31:0] paddr_q,
	output reg pwrite_q,
	output reg [3:0] pstrb_q,
	output reg [2:0] pprot_q,
	output reg [31:0] pwdata_q,
	input wire pready,
	input wire [31:0] prdata,
	input wire pslverr,
	output reg done_q,
	output reg [31:0] rdata_q,
	output reg err_q
);
	reg [3:0] lanes_q;
	wire [31:0] prot_ext;
	wire locked;

	function [3:0] lanes;
		input [2:0] sz;
		input [1:0] a;
		begin
			if (sz == `HSIZE_BYTE)
				lanes = 4'h1 << a;
			else if (sz == `HSIZE_HALF)
				lanes = a[1] ? 4'hc : 4'h3;
			else
				lanes = 4'hf;
		end
	endfunction

	assign prot_ext = {15'h0000, protect};
	assign locked = write & prot_ext[addr[`SLOT_MSB:`SLOT_LSB]];

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			psel_q <= 1'b0;
			penable_q <= 1'b0;
			paddr_q <= 32'h00000000;
			pwrite_q <= 1'b0;
			pstrb_q <= 4'h0;
			pprot_q <= 3'h0;
			pwdata_q <= 32'h00000000;
			lanes_q <= 4'h0;
			done_q <= 1'b0;
			rdata_q <= 32'h00000000;
			err_q <= 1'b0;
		end
		else
		begin
			done_q <= 1'b0;
			if (start)
			begin
				// A stopped bus clock or a write to a locked peripheral never reaches the APB side
				if (!clock_on || locked)
				begin
					done_q <= 1'b1;
					err_q <= 1'b1;
					rdata_q <= 32'h00000000;
				end
				else
				begin
					psel_q <= 1'b1;
					penable_q <= 1'b1;
					paddr_q <= addr;
					pwrite_q <= write;
					pstrb_q <= write ? lanes(size, addr[1:0]) : 4'h0;
					pprot_q <= {~hprot[0], 1'b0, hprot[1]};
					pwdata_q <= wdata;
					lanes_q <= lanes(size, addr[1:0]);
				end
			end
			else if (psel_q && pready)
			begin
				// Wait states simply hold the cycle until the peripheral is ready
				psel_q <= 1'b0;
				penable_q <= 1'b0;
				done_q <= 1'b1;
				err_q <= pslverr;
				rdata_q <= prdata & {{8{lanes_q[3]}}, {8{lanes_q[2]}}, {8{lanes_q[1]}}, {8{lanes_q[0]}}};
			end
		end
	end
endmodule // apb_bridge

/* File: hw/bus_matrix.v */
// Two-master, four-slave crossbar with three peripheral bridges and their protect registers.
// Assumes masters, flash, peripherals and the config port all run on pclk; no crossing needed.
// Functional notes
// - Symmetric crossbar, 32-bit data, each master routed independently to any slave.
// - Different masters reach different slaves concurrently, without serialising.
// - Matrix runs on the masters' clock, no rate conversion.
// - Processor core is master 0, debug unit is master 1.
// - Slaves: flash 0, bridge A 1, bridge B 2, bridge C 3.
// - Each bridge is an AHB slave forwarding to peripherals over APB4-style signals.
// - Bridge carries wait states, errors, protection and byte/halfword/word writes.
// - Address and data appear together in one combined APB cycle.
// - Reads also honour byte and halfword lanes, returning only selected lanes.
// - A bridge works only while its bus clock is enabled from outside.
// - Writing 0 to a clear-register bit leaves protection unchanged.
// - Writing 1 to a clear bit removes protection; reads show 1 while protected.
// - Bridge A protect bits 6..1, reset all zero, clear register at 0x00.
// - Bridge B protect bits 6,3,2,1; reset 0x000002, debug unit protected.
// - Bridge B set register at 0x14, same bits and reset as clear.
// - Bridge C bits: converter 16, timers 15..8, serial 7..2, events 1.
`timescale 1ns/1ps
`include "bmx_consts.vh"
module bus_matrix (
	input wire pclk,
	input wire presetn,
	input wire [1:0] m0_htrans,
	input wire [31:0] m0_haddr,
	input wire m0_hwrite,
	input wire [2:0] m0_hsize,
	input wire [3:0] m0_hprot,
	input wire [31:0] m0_hwdata,
	output wire [31:0] m0_hrdata,
	output wire m0_hready,
	output wire m0_hresp,
	input wire [1:0] m1_htrans,
	input wire [31:0] m1_haddr,
	input wire m1_hwrite,
	input wire [2:0] m1_hsize,
	input wire [3:0] m1_hprot,
	input wire [31:0] m1_hwdata,
	output wire [31:0] m1_hrdata,
	output wire m1_hready,
	output wire m1_hresp,
	output reg flash_hsel_q,
	output reg [1:0] flash_htrans_q,
	output reg [31:0] flash_haddr_q,
	output reg flash_hwrite_q,
	output reg [2:0] flash_hsize_q,
	output reg [3:0] flash_hprot_q,
	output reg [31:0] flash_hwdata_q,
	input wire [31:0] flash_hrdata,
	input wire flash_hready,
	input wire flash_hresp,
	input wire [2:0] bridge_bus_clock_on,
	output wire a_psel,
	output wire a_penable,
	output wire [31:0] a_paddr,
	output wire a_pwrite,
	output wire [3:0] a_pstrb,
	output wire [2:0] a_pprot,
	output wire [31:0] a_pwdata,
	input wire [31:0] a_prdata,
	input wire a_pready,
	input wire a_pslverr,
	output wire b_psel,
	output wire b_penable,
	output wire [31:0] b_paddr,
	output wire b_pwrite,
	output wire [3:0] b_pstrb,
	output wire [2:0] b_pprot,
	output wire [31:0] b_pwdata,
	input wire [31:0] b_prdata,
	input wire b_pready,
	input wire b_pslverr,
	output wire c_psel,
	output wire c_penable,
	output wire [31:0] c_paddr,
	output wire c_pwrite,
	output wire [3:0] c_pstrb,
	output wire [2:0] c_pprot,
	output wire [31:0] c_pwdata,
	input wire [31:0] c_prdata,
	input wire c_pready,
	input wire c_pslverr,
	input wire psel,
	input wire penable,
	input wire [11:0] paddr,
	input wire pwrite,
	input wire [3:0] pstrb,
	input wire [31:0] pwdata,
	output reg [31:0] prdata_q,
	output reg pready_q,
	output reg pslverr_q
);
	localparam M_IDLE = 2'h0;
	localparam M_WAIT = 2'h1;
	localparam M_ERR = 2'h2;
	localparam F_IDLE = 2'h0;
	localparam F_ADDR = 2'h1;
	localparam F_DATA = 2'h2;

	// ----------------------------------------------------------------
	// Address decode shared by both masters
	// ----------------------------------------------------------------
	function [2:0] decode_slave;
		input [31:0] a;
		begin
			if (a[31:28] == `FLASH_REGION)
				decode_slave = `SLV_FLASH;
			else if (a[31:16] == `BRIDGE_A_REGION)
				decode_slave = `SLV_BRIDGE_A;
			else if (a[31:16] == `BRIDGE_B_REGION)
				decode_slave = `SLV_BRIDGE_B;
			else if (a[31:16] == `BRIDGE_C_REGION)
				decode_slave = `SLV_BRIDGE_C;
			else
				decode_slave = `SLV_NONE;
		end
	endfunction

	wire [1:0] m_trans [0:1];
	wire [31:0] m_addr [0:1];
	wire m_write [0:1];
	wire [2:0] m_size [0:1];
	wire [3:0] m_prot [0:1];
	wire [31:0] m_wdata [0:1];
	wire [3:0] want [0:1];
	reg [1:0] st_q [0:1];
	reg [2:0] sel_q [0:1];
	reg [31:0] addr_q [0:1];
	reg write_q [0:1];
	reg [2:0] size_q [0:1];
	reg [3:0] prot_q [0:1];
	reg [1:0] hready_q;
	reg [1:0] hresp_q;
	reg [31:0] hrdata_q [0:1];
	reg [3:0] busy_q;
	reg [3:0] owner_q;
	reg [3:0] start_q;
	wire [3:0] s_done;
	wire [3:0] s_err;
	wire [31:0] s_rdata [0:3];
	wire [31:0] s_addr [0:3];
	wire s_write [0:3];
	wire [2:0] s_size [0:3];
	wire [3:0] s_prot [0:3];
	wire [31:0] s_wdata [0:3];
	reg [1:0] fst_q;
	reg fdone_q;
	reg ferr_q;
	reg [31:0] frdata_q;
	wire [16:0] prot_a;
	wire [16:0] prot_b;
	wire [16:0] prot_c;

	// Core on index 0, debug unit on index 1
	assign m_trans[`MST_CORE] = m0_htrans;
	assign m_addr[`MST_CORE] = m0_haddr;
	assign m_write[`MST_CORE] = m0_hwrite;
	assign m_size[`MST_CORE] = m0_hsize;
	assign m_prot[`MST_CORE] = m0_hprot;
	assign m_wdata[`MST_CORE] = m0_hwdata;
	assign m_trans[`MST_DEBUG] = m1_htrans;
	assign m_addr[`MST_DEBUG] = m1_haddr;
	assign m_write[`MST_DEBUG] = m1_hwrite;
	assign m_size[`MST_DEBUG] = m1_hsize;
	assign m_prot[`MST_DEBUG] = m1_hprot;
	assign m_wdata[`MST_DEBUG] = m1_hwdata;
	assign m0_hready = hready_q[0];
	assign m0_hresp = hresp_q[0];
	assign m0_hrdata = hrdata_q[0];
	assign m1_hready = hready_q[1];
	assign m1_hresp = hresp_q[1];
	assign m1_hrdata = hrdata_q[1];

	// ----------------------------------------------------------------
	// Master ports: one independent request engine per master
	// ----------------------------------------------------------------
	genvar m;
	generate
		for (m = 0; m < 2; m = m + 1)
		begin : g_mst
			wire take;
			wire done;
			assign take = hready_q[m] & m_trans[m][1];
			assign done = (sel_q[m] != `SLV_NONE) & s_done[sel_q[m][1:0]] & (owner_q[sel_q[m][1:0]] == m);
			assign want[m] = ((st_q[m] == M_WAIT) && (sel_q[m] != `SLV_NONE)) ? (4'h1 << sel_q[m][1:0]) : 4'h0;

			always @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
				begin
					st_q[m] <= M_IDLE;
					sel_q[m] <= `SLV_NONE;
					addr_q[m] <= 32'h00000000;
					write_q[m] <= 1'b0;
					size_q[m] <= 3'h0;
					prot_q[m] <= 4'h0;
					hready_q[m] <= 1'b1;
					hresp_q[m] <= 1'b0;
					hrdata_q[m] <= 32'h00000000;
				end
				else
				begin
					case (st_q[m])
						M_IDLE:
						begin
							hresp_q[m] <= 1'b0;
							if (take)
							begin
								st_q[m] <= M_WAIT;
								hready_q[m] <= 1'b0;
								sel_q[m] <= decode_slave(m_addr[m]);
								addr_q[m] <= m_addr[m];
								write_q[m] <= m_write[m];
								size_q[m] <= m_size[m];
								prot_q[m] <= m_prot[m];
							end
						end
						M_WAIT:
						begin
							// Unmapped addresses get the two-cycle error without touching a slave
							if (sel_q[m] == `SLV_NONE)
							begin
								hresp_q[m] <= 1'b1;
								st_q[m] <= M_ERR;
							end
							else if (done)
							begin
								hrdata_q[m] <= s_rdata[sel_q[m][1:0]];
								if (s_err[sel_q[m][1:0]])
								begin
									hresp_q[m] <= 1'b1;
									st_q[m] <= M_ERR;
								end
								else
								begin
									hready_q[m] <= 1'b1;
									st_q[m] <= M_IDLE;
								end
							end
						end
						M_ERR:
						begin
							hready_q[m] <= 1'b1;
							st_q[m] <= M_IDLE;
						end
						default:
						begin
							st_q[m] <= M_IDLE;
							hready_q[m] <= 1'b1;
							hresp_q[m] <= 1'b0;
						end
					endcase
				end
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// Slave ports: per-slave arbiter, core wins a tie
	// ----------------------------------------------------------------
	genvar s;
	generate
		for (s = 0; s < 4; s = s + 1)
		begin : g_slv
			// Each slave arbitrates alone, so two masters on two slaves never wait on each other
			assign s_addr[s] = addr_q[owner_q[s]];
			assign s_write[s] = write_q[owner_q[s]];
			assign s_size[s] = size_q[owner_q[s]];
			assign s_prot[s] = prot_q[owner_q[s]];
			assign s_wdata[s] = m_wdata[owner_q[s]];

			always @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
				begin
					busy_q[s] <= 1'b0;
					owner_q[s] <= `MST_CORE;
					start_q[s] <= 1'b0;
				end
				else
				begin
					start_q[s] <= 1'b0;
					if (!busy_q[s] && (want[0][s] || want[1][s]))
					begin
						busy_q[s] <= 1'b1;
						owner_q[s] <= want[0][s] ? `MST_CORE : `MST_DEBUG;
						start_q[s] <= 1'b1;
					end
					else if (s_done[s])
						busy_q[s] <= 1'b0;
				end
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// Flash port: AHB master toward the flash array
	// ----------------------------------------------------------------
	assign s_done[0] = fdone_q;
	assign s_err[0] = ferr_q;
	assign s_rdata[0] = frdata_q;

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			fst_q <= F_IDLE;
			fdone_q <= 1'b0;
			ferr_q <= 1'b0;
			frdata_q <= 32'h00000000;
			flash_hsel_q <= 1'b0;
			flash_htrans_q <= `HTRANS_IDLE;
			flash_haddr_q <= 32'h00000000;
			flash_hwrite_q <= 1'b0;
			flash_hsize_q <= 3'h0;
			flash_hprot_q <= 4'h0;
			flash_hwdata_q <= 32'h00000000;
		end
		else
		begin
			fdone_q <= 1'b0;
			case (fst_q)
				F_IDLE:
				begin
					if (start_q[0])
					begin
						flash_hsel_q <= 1'b1;
						flash_htrans_q <= `HTRANS_NONSEQ;
						flash_haddr_q <= s_addr[0];
						flash_hwrite_q <= s_write[0];
						flash_hsize_q <= s_size[0];
						flash_hprot_q <= s_prot[0];
						fst_q <= F_ADDR;
					end
				end
				F_ADDR:
				begin
					if (flash_hready)
					begin
						flash_hsel_q <= 1'b0;
						flash_htrans_q <= `HTRANS_IDLE;
						flash_hwdata_q <= s_wdata[0];
						fst_q <= F_DATA;
					end
				end
				F_DATA:
				begin
					if (flash_hready)
					begin
						fdone_q <= 1'b1;
						ferr_q <= flash_hresp;
						frdata_q <= flash_hrdata;
						fst_q <= F_IDLE;
					end
				end
				default:
					fst_q <= F_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Peripheral bridges
	// ----------------------------------------------------------------
	apb_bridge u_bridge_a (
		.pclk(pclk), .presetn(presetn), .clock_on(bridge_bus_clock_on[0]), .start(start_q[1]),
		.addr(s_addr[1]), .write(s_write[1]), .size(s_size[1]), .hprot(s_prot[1]), .wdata(s_wdata[1]),
		.protect(prot_a), .psel_q(a_psel), .penable_q(a_penable), .paddr_q(a_paddr), .pwrite_q(a_pwrite),
		.pstrb_q(a_pstrb), .pprot_q(a_pprot), .pwdata_q(a_pwdata), .pready(a_pready), .prdata(a_prdata),
		.pslverr(a_pslverr), .done_q(s_done[1]), .rdata_q(s_rdata[1]), .err_q(s_err[1])
	);
	apb_bridge u_bridge_b (
		.pclk(pclk), .presetn(presetn), .clock_on(bridge_bus_clock_on[1]), .start(start_q[2]),
		.addr(s_addr[2]), .write(s_write[2]), .size(s_size[2]), .hprot(s_prot[2]), .wdata(s_wdata[2]),
		.protect(prot_b), .psel_q(b_psel), .penable_q(b_penable), .paddr_q(b_paddr), .pwrite_q(b_pwrite),
		.pstrb_q(b_pstrb), .pprot_q(b_pprot), .pwdata_q(b_pwdata), .pready(b_pready), .prdata(b_prdata),
		.pslverr(b_pslverr), .done_q(s_done[2]), .rdata_q(s_rdata[2]), .err_q(s_err[2])
	);
	apb_bridge u_bridge_c (
		.pclk(pclk), .presetn(presetn), .clock_on(bridge_bus_clock_on[2]), .start(start_q[3]),
		.addr(s_addr[3]), .write(s_write[3]), .size(s_size[3]), .hprot(s_prot[3]), .wdata(s_wdata[3]),
		.protect(prot_c), .psel_q(c_psel), .penable_q(c_penable), .paddr_q(c_paddr), .pwrite_q(c_pwrite),
		.pstrb_q(c_pstrb), .pprot_q(c_pprot), .pwdata_q(c_pwdata), .pready(c_pready), .prdata(c_prdata),
		.pslverr(c_pslverr), .done_q(s_done[3]), .rdata_q(s_rdata[3]), .err_q(s_err[3])
	);

	// ----------------------------------------------------------------
	// Configuration APB slave for the protect registers
	// ----------------------------------------------------------------
	wire cfg_acc;
	wire cfg_commit;
	wire [16:0] cfg_wdata;
	wire [31:0] cfg_strb;

	// One wait state: the answer is registered, so pready rises a cycle into the access phase
	assign cfg_acc = psel & penable & ~pready_q;
	assign cfg_commit = psel & penable & pready_q & pwrite;
	assign cfg_strb = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
	assign cfg_wdata = pwdata[16:0] & cfg_strb[16:0];

	protect_regs #(.MASK(`MASK_A), .RESET(`RESET_A)) u_prot_a (
		.pclk(pclk), .presetn(presetn), .clr_we(cfg_commit && (paddr == `OFF_A_CLEAR)),
		.set_we(cfg_commit && (paddr == `OFF_A_SET)), .wdata(cfg_wdata), .prot_q(prot_a)
	);
	protect_regs #(.MASK(`MASK_B), .RESET(`RESET_B)) u_prot_b (
		.pclk(pclk), .presetn(presetn), .clr_we(cfg_commit && (paddr == `OFF_B_CLEAR)),
		.set_we(cfg_commit && (paddr == `OFF_B_SET)), .wdata(cfg_wdata), .prot_q(prot_b)
	);
	protect_regs #(.MASK(`MASK_C), .RESET(`RESET_C)) u_prot_c (
		.pclk(pclk), .presetn(presetn), .clr_we(cfg_commit && (paddr == `OFF_C_CLEAR)),
		.set_we(cfg_commit && (paddr == `OFF_C_SET)), .wdata(cfg_wdata), .prot_q(prot_c)
	);

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready_q <= 1'b0;
			prdata_q <= 32'h00000000;
			pslverr_q <= 1'b0;
		end
		else if (cfg_acc)
		begin
			pready_q <= 1'b1;
			pslverr_q <= 1'b0;
			case (paddr)
				`OFF_A_CLEAR, `OFF_A_SET: prdata_q <= {15'h0000, prot_a};
				`OFF_B_CLEAR, `OFF_B_SET: prdata_q <= {15'h0000, prot_b};
				`OFF_C_CLEAR, `OFF_C_SET: prdata_q <= {15'h0000, prot_c};
				default:
				begin
					prdata_q <= 32'h00000000;
					pslverr_q <= 1'b1;
				end
			endcase
		end
		else
		begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
		end
	end
endmodule // bus_matrix

/* File: dv/bus_matrix_chk.sv */
// Checker for bus_matrix: bridge A, master 0 and the config port.
// Assumes it is bound onto the bus_matrix top; one clock, one reset.
`timescale 1ns/1ps
module bus_matrix_chk (
	input wire pclk,
	input wire presetn,
	input wire m0_hready,
	input wire m0_hresp,
	input wire [2:0] bridge_bus_clock_on,
	input wire a_psel,
	input wire a_penable,
	input wire a_pwrite,
	input wire [3:0] a_pstrb,
	input wire [2:0] a_pprot,
	input wire psel,
	input wire penable,
	input wire pready_q
);
default clocking @(posedge pclk); endclocking
default disable iff (!presetn);
one_cycle_a: assert property (a_psel |-> a_penable) else $error("select without enable");
read_strobe_a: assert property (a_psel && !a_pwrite |-> a_pstrb == 4'h0) else $error("read strobes");
write_strobe_a: assert property (a_psel && a_pwrite |-> a_pstrb != 4'h0) else $error("empty write");
prot_bit_a: assert property (a_psel |-> a_pprot[1] == 1'b0) else $error("bad prot bit");
clock_off_a: assert property (!bridge_bus_clock_on[0] |-> !a_psel) else $error("cycle with clock off");
err_pair_a: assert property (m0_hresp && !m0_hready |=> m0_hresp && m0_hready) else $error("error phase");
err_end_a: assert property (m0_hresp && m0_hready |=> !m0_hresp) else $error("error too long");
cfg_wait_a: assert property ($rose(psel && penable) |=> pready_q) else $error("config late");
cfg_pulse_a: assert property (pready_q |=> !pready_q) else $error("config ready stuck");
stall_bound_a: assert property ($fell(m0_hready) |-> ##[1:40] m0_hready) else $error("master hung");
endmodule // bus_matrix_chk

bind bus_matrix bus_matrix_chk chk_i (.pclk(pclk), .presetn(presetn), .m0_hready(m0_hready), .m0_hresp(m0_hresp),
	.bridge_bus_clock_on(bridge_bus_clock_on), .a_psel(a_psel), .a_penable(a_penable), .a_pwrite(a_pwrite),
	.a_pstrb(a_pstrb), .a_pprot(a_pprot), .psel(psel), .penable(penable), .pready_q(pready_q));

/* File: dv/periph_model.sv */
// Peripheral register block behind one bridge: one word of storage.
// Assumes waits changes only between transfers; offset 0xffc answers with an error.
`timescale 1ns/1ps
module periph_model (
	input wire pclk,
	input wire presetn,
	input wire [1:0] waits,
	input wire psel,
	input wire penable,
	input wire [31:0] paddr,
	input wire pwrite,
	input wire [3:0] pstrb,
	input wire [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr
);
logic [1:0] cnt_q;
logic [31:0] mem_q;
logic [31:0] junk_q;
wire hit = psel && penable && cnt_q == waits;
assign pready = hit;
assign pslverr = hit && paddr[11:0] == 12'hffc;
// Outside the answer cycle the data lines carry junk_q, which negates to itself and stays zero after reset
assign prdata = hit ? mem_q : junk_q;
always @(posedge pclk or negedge presetn)
	if (!presetn)
	begin
		cnt_q <= 2'h0;
		mem_q <= 32'h0;
		junk_q <= 32'h0;
	end
	else
	begin
		junk_q <= ~junk_q + 32'h1;
		cnt_q <= (psel && penable && !hit) ? cnt_q + 2'h1 : 2'h0;
		if (hit && pwrite)
			for (int i = 0; i < 4; i++)
				if (pstrb[i])
					mem_q[8*i +: 8] <= pwdata[8*i +: 8];
	end
endmodule // periph_model

/* File: dv/bus_matrix_test.sv */
// Self-checking bench for bus_matrix: config APB port, two masters, three bridge peripherals.
// Assumes flash is always ready with one fixed word.
`timescale 1ns/1ps
module bus_matrix_test;
localparam logic [31:0] FW = 32'hc3a5_5a3c;
localparam logic [33:0] WR = 34'h0;
localparam logic [33:0] ER = {2'b01, 32'h0};
logic pclk = 0, presetn = 0, csel = 0, cen = 0, cwr = 0;
logic [11:0] cad = 0;
logic [31:0] cwd = 0, d;
logic [3:0] cst = 4'hf;
logic [2:0] con = 3'h7, sz;
logic [1:0] wt = 0, o;
logic [1:0] htr[2] = '{2'h0, 2'h0};
logic [31:0] had[2] = '{0, 0}, hwd[2] = '{0, 0}, em[3] = '{0, 0, 0};
logic hwr[2] = '{0, 0}, busy[2] = '{0, 0};
logic [2:0] hsz[2] = '{0, 0};
wire [31:0] hrd[2], crd, pa[3], pwd[3], prd[3];
wire hrdy[2], hrsp[2], crdy, cerr, ps[3], pe[3], pw[3], prdy[3], perr[3];
wire [3:0] pst[3];
logic [33:0] cq[$], mq[2][$];
int miscompares = 0, total_checks = 0, cyc = 0;
always #5 pclk = ~pclk;
bus_matrix bus_matrix_i (.pclk(pclk), .presetn(presetn), .m0_htrans(htr[0]), .m0_haddr(had[0]), .m0_hwrite(hwr[0]),
	.m0_hsize(hsz[0]), .m0_hprot(4'h3), .m0_hwdata(hwd[0]), .m0_hrdata(hrd[0]), .m0_hready(hrdy[0]), .m0_hresp(hrsp[0]),
	.m1_htrans(htr[1]), .m1_haddr(had[1]), .m1_hwrite(hwr[1]), .m1_hsize(hsz[1]), .m1_hprot(4'h3), .m1_hwdata(hwd[1]),
	.m1_hrdata(hrd[1]), .m1_hready(hrdy[1]), .m1_hresp(hrsp[1]), .flash_hsel_q(), .flash_htrans_q(), .flash_haddr_q(),
	.flash_hwrite_q(), .flash_hsize_q(), .flash_hprot_q(), .flash_hwdata_q(), .flash_hrdata(FW), .flash_hready(1'b1),
	.flash_hresp(1'b0), .bridge_bus_clock_on(con), .a_psel(ps[0]), .a_penable(pe[0]), .a_paddr(pa[0]), .a_pwrite(pw[0]),
	.a_pstrb(pst[0]), .a_pprot(), .a_pwdata(pwd[0]), .a_prdata(prd[0]), .a_pready(prdy[0]), .a_pslverr(perr[0]),
	.b_psel(ps[1]), .b_penable(pe[1]), .b_paddr(pa[1]), .b_pwrite(pw[1]), .b_pstrb(pst[1]), .b_pprot(),
	.b_pwdata(pwd[1]), .b_prdata(prd[1]), .b_pready(prdy[1]), .b_pslverr(perr[1]), .c_psel(ps[2]), .c_penable(pe[2]),
	.c_paddr(pa[2]), .c_pwrite(pw[2]), .c_pstrb(pst[2]), .c_pprot(), .c_pwdata(pwd[2]), .c_prdata(prd[2]),
	.c_pready(prdy[2]), .c_pslverr(perr[2]), .psel(csel), .penable(cen), .paddr(cad), .pwrite(cwr), .pstrb(cst),
	.pwdata(cwd), .prdata_q(crd), .pready_q(crdy), .pslverr_q(cerr));
for (genvar g = 0; g < 3; g++)
begin : per
	periph_model periph_model_i (.pclk(pclk), .presetn(presetn), .waits(wt), .psel(ps[g]), .penable(pe[g]),
		.paddr(pa[g]), .pwrite(pw[g]), .pstrb(pst[g]), .pwdata(pwd[g]), .prdata(prd[g]), .pready(prdy[g]),
		.pslverr(perr[g]));
end
function automatic logic [33:0] rd(input logic [31:0] v);
	rd = {2'b10, v};
endfunction
function automatic logic [31:0] lanes(input logic [2:0] s, input logic [1:0] a);
	lanes = s == 3'h0 ? 32'hff << (8 * a) : s == 3'h1 ? 32'hffff << (8 * a) : 32'hffffffff;
endfunction
task automatic cmp(input string what, input logic [33:0] e, input logic err, input logic [31:0] v);
	total_checks++;
	if (err !== e[32] || (e[33] && v !== e[31:0]))
	begin
		miscompares++;
		$display("ERROR %s expected %h seen %h", what, e[32:0], {err, v});
	end
endtask
task automatic cfg(input logic w, input logic [11:0] a, input logic [31:0] v, input logic [33:0] e);
	cq.push_back(e);
	@(posedge pclk);
	csel <= 1; cen <= 0; cwr <= w; cad <= a; cwd <= v;
	@(posedge pclk);
	cen <= 1;
	do @(posedge pclk); while (crdy !== 1'b1);
	csel <= 0; cen <= 0;
endtask
task automatic ahb(input int m, input logic w, input logic [31:0] a, input logic [2:0] s, input logic [31:0] v,
	input logic [33:0] e);
	mq[m].push_back(e);
	@(posedge pclk);
	htr[m] <= 2'h2; had[m] <= a; hwr[m] <= w; hsz[m] <= s;
	do @(posedge pclk); while (hrdy[m] !== 1'b1);
	htr[m] <= 2'h0; hwd[m] <= v;
	do @(posedge pclk); while (hrdy[m] !== 1'b1);
endtask
task automatic finish_test;
	$display("checks %0d mismatches %0d", total_checks, miscompares);
	if (miscompares == 0 && total_checks > 0)
		$display("All tests passed");
	else
		$display("Some tests failed");
	$finish;
endtask
// ----------------------------------------------------------------
// Result watchers: oldest note against each answer
// ----------------------------------------------------------------
always @(posedge pclk)
begin
	if (crdy === 1'b1)
		cmp("config", cq.pop_front(), cerr, crd);
	for (int m = 0; m < 2; m++)
	begin
		if (busy[m] && hrdy[m] === 1'b1)
			cmp("master", mq[m].pop_front(), hrsp[m], hrd[m]);
		if (hrdy[m] === 1'b1)
			busy[m] = htr[m][1];
	end
	cyc++;
	if (cyc == 20000)
	begin
		miscompares++;
		finish_test();
	end
end
// ----------------------------------------------------------------
// Scenarios
// ----------------------------------------------------------------
initial
begin
	void'($urandom(92));
	repeat (6) @(posedge pclk);
	presetn <= 1;
	cfg(0, 12'h000, 0, rd(0));
	cfg(0, 12'h010, 0, rd(2));
	cfg(0, 12'h014, 0, rd(2));
	cfg(0, 12'h020, 0, rd(0));
	cfg(0, 12'h030, 0, ER);
	cfg(1, 12'h010, 0, WR);
	cfg(0, 12'h010, 0, rd(2));
	cfg(1, 12'h014, '1, WR);
	cfg(0, 12'h010, 0, rd(32'h4e));
	// Only the low byte lane is enabled, so only the serial and event bits may set
	cst <= 4'h1;
	cfg(1, 12'h024, '1, WR);
	cfg(0, 12'h020, 0, rd(32'hfe));
	cst <= 4'hf;
	cfg(1, 12'h024, '1, WR);
	cfg(0, 12'h020, 0, rd(32'h1fffe));
	cfg(1, 12'h004, '1, WR);
	cfg(0, 12'h000, 0, rd(32'h7e));
	ahb(0, 1, 32'h4000_0800, 3'h2, 32'h1234_5678, ER);
	cfg(1, 12'h000, 32'h4, WR);
	cfg(0, 12'h004, 0, rd(32'h7a));
	cfg(1, 12'h000, '1, WR);
	for (int i = 0; i < 16; i++)
	begin
		sz = 3'($urandom % 3);
		o = sz == 3'h0 ? 2'($urandom) : sz == 3'h1 ? {1'($urandom), 1'b0} : 2'h0;
		d = $urandom;
		wt <= 2'($urandom);
		ahb(0, 1, {30'h1000_0000, o}, sz, d, WR);
		em[0] = (em[0] & ~lanes(sz, o)) | (d & lanes(sz, o));
		ahb(0, 0, {30'h1000_0000, o}, sz, 0, rd(em[0] & lanes(sz, o)));
	end
	ahb(0, 0, 32'h4000_0ffc, 3'h2, 0, ER);
	ahb(1, 1, 32'h4100_0400, 3'h2, 32'h1, ER);
	ahb(1, 0, 32'h4100_0400, 3'h2, 0, rd(em[1]));
	con <= 3'h6;
	ahb(0, 0, 32'h4000_0000, 3'h2, 0, ER);
	con <= 3'h7;
	ahb(0, 1, 32'h4200_0400, 3'h2, 32'h5, ER);
	ahb(0, 0, 32'h5000_0000, 3'h2, 0, ER);
	fork
		ahb(0, 0, 32'h4000_0000, 3'h2, 0, rd(em[0]));
		ahb(1, 0, 32'h0000_0100, 3'h2, 0, rd(FW));
	join
	fork
		ahb(0, 0, 32'h4000_0000, 3'h2, 0, rd(em[0]));
		ahb(1, 0, 32'h4000_0000, 3'h2, 0, rd(em[0]));
	join
	repeat (3) @(posedge pclk);
	finish_test();
end
endmodule // bus_matrix_test
